// File: link_monitor_sva.sv
// Assertions on the link monitor ports.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module link_monitor_sva #(
  parameter int unsigned LINK_TIMEOUT = 200,
  parameter int unsigned PULSE_PERIOD = 50,
  parameter int unsigned PULSE_WIDTH  = 13
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Transmit side
  input wire logic txValid,
  input wire logic txData,
  input wire logic txLineEn,
  input wire logic txLine,
  // Receive side
  input wire logic rxLine,
  input wire logic rxLinePulse,
  input wire logic rxLinePulseInv,
  input wire logic rxFrameEnd,
  input wire logic rxFrameInv,
  input wire logic rxActive,
  input wire logic rxValid,
  input wire logic rxData,
  // Status
  input wire logic linkUp,
  input wire logic linkLed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic        act;
  logic        invSeen;
  int unsigned quiet, enCnt, gap;
  assign act = rxActive | rxLinePulse | rxLinePulseInv | rxFrameEnd;
  // =========================================
  // Helper counters
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      quiet   <= LINK_TIMEOUT + 2;
      gap     <= 0;
      invSeen <= 1'b0;
    end else begin
      quiet <= act ? 0 : (quiet > LINK_TIMEOUT + 1 ? quiet : quiet + 1);
      gap   <= (txValid | $past(txValid)) ? 0 :
               ($rose(txLineEn) ? 1 : (gap != 0 ? gap + 1 : 0));
      invSeen <= invSeen | rxLinePulseInv | (rxFrameEnd & rxFrameInv);
    end
    enCnt <= txLineEn ? enCnt + 1 : 0;
  end
  // =========================================
  // Properties
  property p_rise; act |=> linkUp; endproperty
  a_rise: assert property (p_rise) else $error("no link");
  property p_fall;
    $fell(linkUp) |-> quiet inside {[LINK_TIMEOUT-2:LINK_TIMEOUT]};
  endproperty
  a_fall: assert property (p_fall) else $error("early drop");
  property p_drop; quiet > LINK_TIMEOUT |-> !linkUp; endproperty
  a_drop: assert property (p_drop) else $error("no drop");
  property p_led; linkLed == linkUp; endproperty
  a_led: assert property (p_led) else $error("led wrong");
  property p_rxb; !linkUp ##1 !linkUp |-> !rxValid; endproperty
  a_rxb: assert property (p_rxb) else $error("rx leak");
  property p_txb; !linkUp ##1 !linkUp |-> txLineEn == txLine; endproperty
  a_txb: assert property (p_txb) else $error("tx leak");
  property p_rxd; !invSeen |=> rxData == $past(rxLine); endproperty
  a_rxd: assert property (p_rxd) else $error("bad rx data");
  property p_wid; $fell(txLineEn) && !linkUp |-> enCnt == PULSE_WIDTH;
  endproperty
  a_wid: assert property (p_wid) else $error("pulse width");
  property p_per; $rose(txLineEn) && gap != 0 |-> gap == PULSE_PERIOD;
  endproperty
  a_per: assert property (p_per) else $error("pulse period");
endmodule : link_monitor_sva
bind twisted_pair_link_monitor link_monitor_sva #(
  .LINK_TIMEOUT (LINK_TIMEOUT),
  .PULSE_PERIOD (PULSE_PERIOD),
  .PULSE_WIDTH  (PULSE_WIDTH)
) link_monitor_sva_inst (
  .sys_clk        (sys_clk),
  .rst_n          (rst_n),
  .txValid        (txValid),
  .txData         (txData),
  .txLineEn       (txLineEn),
  .txLine         (txLine),
  .rxLine         (rxLine),
  .rxLinePulse    (rxLinePulse),
  .rxLinePulseInv (rxLinePulseInv),
  .rxFrameEnd     (rxFrameEnd),
  .rxFrameInv     (rxFrameInv),
  .rxActive       (rxActive),
  .rxValid        (rxValid),
  .rxData         (rxData),
  .linkUp         (linkUp),
  .linkLed        (linkLed)
);
`default_nettype wire

// File: link_pulse_gen.sv
// Idle link test pulse generator.
// Assumes the caller holds idleEn high whenever no frame data is sent.
`timescale 1ns/100ps
`default_nettype none
`include "tp_link_defines.svh"

module link_pulse_gen #(
  parameter int unsigned INTERVAL_CYC = 32'(`PULSE_INTERVAL_CYC),
  parameter int unsigned WIDTH_CYC    = 32'(`PULSE_WIDTH_CYC)
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic idleEn,
  // Pulse out
  output var  logic linkPulse
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        pulse_reg;
  logic        pulse_next;

  // ========================================================
  // Interval counter
  // ========================================================
  always_comb begin
    cnt_next   = cnt_reg;
    pulse_next = 1'b0;
    if (!idleEn) begin
      cnt_next = 32'h0;
    end else begin
      // RQ1 periodic pulse timing
      if (cnt_reg >= INTERVAL_CYC - 32'h1) begin
        cnt_next = 32'h0;
      end else begin
        cnt_next = cnt_reg + 32'h1;
      end
      pulse_next = (cnt_reg < WIDTH_CYC);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg   <= 32'h0;
      pulse_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign linkPulse = pulse_reg;

endmodule : link_pulse_gen
`default_nettype wire

// File: remote_xcvr_model.sv
// Far-end transceiver: sends link pulses and frames as decoder events.
// Assumes the caller works at falling clock edges.
`timescale 1ns/100ps
`default_nettype none
module remote_xcvr_model (
  input  wire logic sys_clk,
  output wire logic rxLine,
  output var  logic rxLinePulse, rxLinePulseInv, rxFrameEnd, rxFrameInv,
  output var  logic rxActive
);
  logic tog = 0, dbit = 0;
  int   seed = 32'h959ABC42;
  initial {rxLinePulse, rxLinePulseInv, rxFrameEnd, rxFrameInv} = 4'h0;
  initial rxActive = 0;
  // Idle line flips every cycle so no stale level survives
  always @(negedge sys_clk) tog <= ~tog;
  assign rxLine = rxActive ? dbit : tog;
  task automatic pulse(input logic inv);
    @(negedge sys_clk);
    rxLinePulse = ~inv;
    rxLinePulseInv = inv;
    @(negedge sys_clk);
    {rxLinePulse, rxLinePulseInv} = 2'h0;
    @(negedge sys_clk);
  endtask : pulse
  task automatic frame(input logic inv);
    pulse(1'b0);
    repeat (4) begin
      @(negedge sys_clk);
      rxActive = 1;
      dbit = $random(seed);
    end
    @(negedge sys_clk);
    rxActive = 0;
    {rxFrameEnd, rxFrameInv} = {1'b1, inv};
    @(negedge sys_clk);
    {rxFrameEnd, rxFrameInv} = 2'h0;
  endtask : frame
endmodule : remote_xcvr_model
`default_nettype wire

// File: test_twisted_pair_link_monitor.sv
// Self-checking bench for the link monitor.
// Assumes the far-end model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module test_twisted_pair_link_monitor;
  logic sys_clk = 0, rst_n = 0, txValid = 0, txData = 0, expCorr = 0, e;
  wire logic txLineEn, txLine, rxLine, rxLinePulse, rxLinePulseInv;
  wire logic rxFrameEnd, rxFrameInv, rxActive, rxValid, rxData;
  wire logic linkUp, linkLed;
  int num_errors = 0, samples_checked = 0, cyc = 0, seed = 32'h959ABC42;
  logic rq[$], tq[$];
  logic armed = 0;
  always #4 sys_clk = ~sys_clk;
  twisted_pair_link_monitor #(
    .LINK_TIMEOUT (200),
    .PULSE_PERIOD (50),
    .PULSE_WIDTH  (13)
  ) twisted_pair_link_monitor_inst (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .txValid        (txValid),
    .txData         (txData),
    .txLineEn       (txLineEn),
    .txLine         (txLine),
    .rxLine         (rxLine),
    .rxLinePulse    (rxLinePulse),
    .rxLinePulseInv (rxLinePulseInv),
    .rxFrameEnd     (rxFrameEnd),
    .rxFrameInv     (rxFrameInv),
    .rxActive       (rxActive),
    .rxValid        (rxValid),
    .rxData         (rxData),
    .linkUp         (linkUp),
    .linkLed        (linkLed)
  );
  remote_xcvr_model remote_xcvr_model_inst (
    .sys_clk        (sys_clk),
    .rxLine         (rxLine),
    .rxLinePulse    (rxLinePulse),
    .rxLinePulseInv (rxLinePulseInv),
    .rxFrameEnd     (rxFrameEnd),
    .rxFrameInv     (rxFrameInv),
    .rxActive       (rxActive)
  );
  task automatic check_rx(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %0t: rx got %b want %b", $time, g, x);
    end
  endtask : check_rx
  task automatic check_tx(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %0t: tx got %b want %b", $time, g, x);
    end
  endtask : check_tx
  task automatic check_link(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %0t: link got %b want %b", $time, g, x);
    end
  endtask : check_link
  task test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task tx_burst;
    repeat (20) begin
      @(negedge sys_clk);
      txValid = $random(seed);
      txData = $random(seed);
    end
    @(negedge sys_clk);
    txValid = 0;
  endtask : tx_burst
  // =========================================
  // Notes taken at each edge, checked one edge later
  // Outputs hold no value before the first reset edge
  always @(posedge sys_clk) begin
    armed <= 1'b1;
    if (armed) begin
      if (rq.size() > 0) begin
        e = rq.pop_front();
        check_rx(rxValid, 1'b1);
        if (e !== 1'bx) check_rx(rxData, e);
      end else check_rx(rxValid, 1'b0);
      if (tq.size() > 0) begin
        e = tq.pop_front();
        check_tx(txLineEn & txLine, e);
      end
    end
    if (rst_n && linkUp && rxActive) rq.push_back(rxLine ^ expCorr);
    if (rst_n && linkUp && txValid) tq.push_back(txData);
  end
  // Run limit
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1;
    check_link(linkUp, 1'b0);
    tx_burst();
    repeat (110) @(negedge sys_clk);
    repeat (5) remote_xcvr_model_inst.pulse(1'b1);
    remote_xcvr_model_inst.pulse(1'b0);
    check_link(linkUp, 1'b1);
    repeat (5) remote_xcvr_model_inst.pulse(1'b1);
    tx_burst();
    remote_xcvr_model_inst.frame(1'b1);
    remote_xcvr_model_inst.frame(1'b0);
    repeat (2) remote_xcvr_model_inst.frame(1'b1);
    repeat (210) @(negedge sys_clk);
    check_link(linkLed, 1'b0);
    repeat (6) remote_xcvr_model_inst.pulse(1'b1);
    expCorr = 1;
    repeat (2) remote_xcvr_model_inst.frame(1'b0);
    @(negedge sys_clk);
    rst_n = 0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1;
    expCorr = 0;
    repeat (2) remote_xcvr_model_inst.frame(1'b1);
    expCorr = 1;
    remote_xcvr_model_inst.frame(1'b1);
    repeat (4) @(negedge sys_clk);
    test_done();
  end
endmodule : test_twisted_pair_link_monitor
`default_nettype wire

// File: tp_link_defines.svh
// Timing constants and polarity thresholds for the twisted-pair link monitor.
// Assumes a 125 MHz system clock (8 ns period).
`ifndef TP_LINK_DEFINES_SVH
`define TP_LINK_DEFINES_SVH

// ==========================================================
// Clock
// ==========================================================
`define CLK_PERIOD_PS        8000

// ==========================================================
// Link test pulse timing
// ==========================================================
`define PULSE_WIDTH_NS       100
// Least time: round up
`define PULSE_WIDTH_CYC      ((`PULSE_WIDTH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PULSE_INTERVAL_MS    16
`define PULSE_INTERVAL_CYC   ((`PULSE_INTERVAL_MS * 64'd1000000000) / `CLK_PERIOD_PS)

// ==========================================================
// Link loss timeout
// ==========================================================
`define LINK_TIMEOUT_MS      100
`define LINK_TIMEOUT_CYC     ((`LINK_TIMEOUT_MS * 64'd1000000000) / `CLK_PERIOD_PS)

// ==========================================================
// Polarity thresholds
// ==========================================================
`define INV_FRAME_LIMIT      2
`define INV_PULSE_LIMIT      6

`endif

// File: tp_link_pkg.sv
// Types for the twisted-pair link monitor.
// No assumptions beyond a SystemVerilog compiler.
package tp_link_pkg;

  // ========================================================
  // Polarity monitor states
  // ========================================================
  typedef enum logic [1:0] {
    POL_MONITOR,
    POL_GOOD,
    POL_CORRECTED
  } pol_state_t;

endpackage : tp_link_pkg

// File: twisted_pair_link_monitor.sv
// Per-port 10BASE-T link integrity and autopolarity monitor.
// Assumes receive events are decoded upstream as one-cycle pulses.
// Functional notes
// RQ1 - Send idle link pulses when not transmitting
// RQ2 - Drop link after inactivity timeout
// RQ3 - Block transmit and receive without link
// RQ4 - Activity restores link and restarts timer
// RQ5 - Monitor polarity only at reset or linkless
// RQ6 - One normal frame marks polarity good
// RQ7 - Two inverted frames or six pulses correct
// RQ8 - Correction stops monitoring until link loss
// RQ9 - Correction inverts the received line signal
// RQ10 - Inverted pulses count toward correction
// RQ11 - No external polarity indicator exists
// RQ12 - Reset clears link, correction; starts monitoring
`timescale 1ns/100ps
`default_nettype none
`include "tp_link_defines.svh"

module twisted_pair_link_monitor
  import tp_link_pkg::*;
#(
  parameter int unsigned LINK_TIMEOUT = 32'(`LINK_TIMEOUT_CYC),
  parameter int unsigned PULSE_PERIOD = 32'(`PULSE_INTERVAL_CYC),
  parameter int unsigned PULSE_WIDTH  = 32'(`PULSE_WIDTH_CYC)
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Repeater core transmit side
  input  wire logic txValid,
  input  wire logic txData,
  // Transmit pair
  output var  logic txLineEn,
  output var  logic txLine,
  // Receive pair: line and activity levels, plus one-cycle event pulses from the line decoder
  input  wire logic rxLine,
  input  wire logic rxLinePulse,
  input  wire logic rxLinePulseInv,
  input  wire logic rxFrameEnd,
  input  wire logic rxFrameInv,
  input  wire logic rxActive,
  // Repeater core receive side
  output var  logic rxValid,
  output var  logic rxData,
  // Status
  output var  logic linkUp,
  output var  logic linkLed
);
  import tp_link_pkg::*;

  logic        link_reg;
  logic        link_next;
  logic [31:0] idle_reg;
  logic [31:0] idle_next;
  pol_state_t  pol_reg;
  pol_state_t  pol_next;
  logic [1:0]  invFrm_reg;
  logic [1:0]  invFrm_next;
  logic [2:0]  invPls_reg;
  logic [2:0]  invPls_next;
  logic        txEn_reg;
  logic        txEn_next;
  logic        txLine_reg;
  logic        txLine_next;
  logic        rxValid_reg;
  logic        rxValid_next;
  logic        rxData_reg;
  logic        rxData_next;
  logic        linkPulse;
  logic        activity;
  logic        correct;
  logic        txGate;

  // RQ4 any activity
  assign activity = rxActive | rxLinePulse | rxLinePulseInv
                  | rxFrameEnd;
  assign correct  = (pol_reg == POL_CORRECTED);
  // RQ3 frame data only with link
  assign txGate   = txValid & link_reg;

  // ========================================================
  // Idle pulse generator
  // ========================================================
  // RQ1 idle pattern when not sending
  // Pulses keep running while link is down, so the far end
  // can still find us and bring the link back
  link_pulse_gen #(
    .INTERVAL_CYC (PULSE_PERIOD),
    .WIDTH_CYC    (PULSE_WIDTH)
  ) u_pulse (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .idleEn    (~txGate),
    .linkPulse (linkPulse)
  );

  // ========================================================
  // Link integrity
  // ========================================================
  // Counter parks one below the limit while link is down,
  // so the next activity restarts a full timeout
  always_comb begin
    link_next = link_reg;
    idle_next = idle_reg;
    if (activity) begin
      // RQ4 restore and restart
      link_next = 1'b1;
      idle_next = 32'h0;
    end else if (idle_reg >= LINK_TIMEOUT - 32'h1) begin
      // RQ2 timeout drops link
      link_next = 1'b0;
    end else begin
      idle_next = idle_reg + 32'h1;
    end
  end

  // ========================================================
  // Polarity detection
  // ========================================================
  always_comb begin
    pol_next    = pol_reg;
    invFrm_next = invFrm_reg;
    invPls_next = invPls_reg;
    case (pol_reg)
      POL_MONITOR: begin
        if (rxFrameEnd && !rxFrameInv) begin
          // RQ6 normal frame good
          pol_next    = POL_GOOD;
          invFrm_next = 2'h0;
          invPls_next = 3'h0;
        end else begin
          // A frame ends a run of inverted pulses unless an inverted pulse in the same cycle extends it
          if (rxFrameEnd) begin
            invFrm_next = invFrm_reg + 2'h1;
            invPls_next = 3'h0;
          end
          // RQ10 inverted pulses count
          if (rxLinePulseInv) begin
            invPls_next = invPls_reg + 3'h1;
          end else if (rxLinePulse) begin
            invPls_next = 3'h0;
          end
          // Thresholds look at the next counts, so the final
          // pulse or frame switches correction at once
          // RQ7 correction thresholds
          if (invFrm_next >= 2'(`INV_FRAME_LIMIT) ||
              invPls_next >= 3'(`INV_PULSE_LIMIT)) begin
            pol_next = POL_CORRECTED;
          end
        end
      end
      POL_GOOD, POL_CORRECTED: begin
        // RQ8 resume only on link loss
        if (!link_reg) begin
          pol_next    = POL_MONITOR;
          invFrm_next = 2'h0;
          invPls_next = 3'h0;
        end
      end
      default: pol_next = POL_MONITOR;
    endcase
    // RQ5 monitor only when linkless
    // Link loss reopens monitoring from any verdict
    if (!link_reg && pol_reg != POL_MONITOR) begin
      pol_next = POL_MONITOR;
    end
  end

  // ========================================================
  // Data paths
  // ========================================================
  always_comb begin
    // RQ3 transmit gated by link
    // Data wins over a pulse still draining from the generator
    txEn_next   = txGate | linkPulse;
    txLine_next = txGate ? txData : linkPulse;
    // RQ3 receive gated by link
    rxValid_next = link_reg & rxActive;
    // rxData runs freely; rxValid alone marks it forwarded
    // RQ9 internal inversion
    rxData_next  = rxLine ^ correct;
  end

  // ========================================================
  // Registers
  // ========================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // RQ12 reset state
      link_reg    <= 1'b0;
      idle_reg    <= 32'h0;
      pol_reg     <= POL_MONITOR;
      invFrm_reg  <= 2'h0;
      invPls_reg  <= 3'h0;
      txEn_reg    <= 1'b0;
      txLine_reg  <= 1'b0;
      rxValid_reg <= 1'b0;
      rxData_reg  <= 1'b0;
    end else begin
      link_reg    <= link_next;
      idle_reg    <= idle_next;
      pol_reg     <= pol_next;
      invFrm_reg  <= invFrm_next;
      invPls_reg  <= invPls_next;
      txEn_reg    <= txEn_next;
      txLine_reg  <= txLine_next;
      rxValid_reg <= rxValid_next;
      rxData_reg  <= rxData_next;
    end
  end

  // ========================================================
  // Outputs
  // ========================================================
  // RQ11 polarity state kept internal
  assign txLineEn = txEn_reg;
  assign txLine   = txLine_reg;
  assign rxValid  = rxValid_reg;
  assign rxData   = rxData_reg;
  assign linkUp   = link_reg;
  // RQ2 indicator follows link status
  assign linkLed  = link_reg;

endmodule : twisted_pair_link_monitor
`default_nettype wire
